/* hdl/ospwr_cfg_if.sv */
// Configuration and status carrier between the register bank and its helpers
`timescale 1ns/10ps
interface ospwr_cfg_if;
  logic [7:0] op_ctrl;
  logic [7:0] dec_ctrl;
  logic [3:0] adc_en;
  logic [3:0] dmic_sel;
  logic [1:0] neg_en;
  logic [1:0] pos_en;
  logic [1:0] hp_mode;
  logic [1:0] settled;
  logic [3:0] filt_clk;
  logic [3:0] dec_clk;
  logic [3:0] run;
  logic [3:0] analog;
  modport stage (input op_ctrl, output neg_en, pos_en, hp_mode, settled);
  modport gate (input dec_ctrl, adc_en, dmic_sel, output filt_clk, dec_clk, run, analog);
endinterface

/* hdl/ospwr_gate.sv */
// Filter and decimator clock enables derived from the decimator power register
`timescale 1ns/10ps
module ospwr_gate import ospwr_pkg::*; #(
  parameter int FILT_DIV = OSPWR_FILT_DIV
) (
  input wire logic clk,
  input wire logic reset,
  ospwr_cfg_if.gate cfg
);
  localparam int DW = (FILT_DIV > 1) ? $clog2(FILT_DIV) : 1;
  logic [DW-1:0] div_r;
  logic [DW-1:0] div_nxt;
  logic tick;
  wire [3:0] filt_on = cfg.dec_ctrl[OSPWR_FILT_LSB +: OSPWR_NCHAN];
  wire [3:0] dec_on = cfg.dec_ctrl[OSPWR_DEC_LSB +: OSPWR_NCHAN];

  assign tick = (div_r == DW'(FILT_DIV - 1));
  assign div_nxt = tick ? '0 : div_r + 1'h1;

  always_ff @(posedge clk) begin
    if (reset) begin
      div_r <= '0;
      cfg.filt_clk <= '0;
      cfg.dec_clk <= '0;
      cfg.run <= '0;
      cfg.analog <= '0;
    end else begin
      div_r <= div_nxt;
      cfg.filt_clk <= tick ? filt_on : 4'h0;
      cfg.dec_clk <= tick ? dec_on : 4'h0;
      // A digital microphone channel runs without its converter enable
      cfg.run <= filt_on & (cfg.adc_en | cfg.dmic_sel);
      cfg.analog <= filt_on & cfg.adc_en;
    end
  end

  if (FILT_DIV < 1) begin : g_chk
    $error("FILT_DIV must be at least one");
  end
endmodule

/* hdl/ospwr_pkg.sv */
// Constants for the output stage and decimator power register bank
package ospwr_pkg;
  localparam int OSPWR_AW = 8;
  localparam int OSPWR_DW = 8;
  localparam logic [7:0] OSPWR_OP_STAGE_ADDR = 8'h43;
  localparam logic [7:0] OSPWR_DECIM_ADDR = 8'h44;
  localparam logic [7:0] OSPWR_STATUS_ADDR = 8'h4F;
  localparam logic [7:0] OSPWR_OP_STAGE_RST = 8'h0F;
  localparam logic [7:0] OSPWR_DECIM_RST = 8'h00;
  localparam logic [7:0] OSPWR_UNMAPPED_DATA = 8'h00;
  localparam int OSPWR_RMODE_BIT = 5;
  localparam int OSPWR_LMODE_BIT = 4;
  localparam int OSPWR_RPWR_LSB = 2;
  localparam int OSPWR_LPWR_LSB = 0;
  localparam int OSPWR_DEC_LSB = 4;
  localparam int OSPWR_FILT_LSB = 0;
  localparam int OSPWR_NCHAN = 4;
  localparam int OSPWR_STAT_SETTLED_LSB = 0;
  localparam int OSPWR_STAT_RUN_LSB = 4;
  typedef enum logic [1:0] {
    OSPWR_PWR_BOTH = 2'h0,
    OSPWR_PWR_NEG_ONLY = 2'h1,
    OSPWR_PWR_POS_ONLY = 2'h2,
    OSPWR_PWR_DOWN = 2'h3
  } ospwr_pwr_e;
  localparam longint OSPWR_CLK_HZ = 64'd100_000_000;
  localparam longint OSPWR_SETTLE_MS = 64'd6;
  // Least time: round up to whole cycles
  localparam int OSPWR_SETTLE_CYC = int'((OSPWR_SETTLE_MS * OSPWR_CLK_HZ + 64'd999) / 64'd1000);
  localparam int OSPWR_FILT_DIV = 4;
endpackage

/* hdl/ospwr_stage.sv */
// Output stage decode and headphone settle timers, index 0 left, 1 right
`timescale 1ns/10ps
module ospwr_stage import ospwr_pkg::*; #(
  parameter int SETTLE_CYCLES = OSPWR_SETTLE_CYC
) (
  input wire logic clk,
  input wire logic reset,
  ospwr_cfg_if.stage cfg
);
  localparam int CW = $clog2(SETTLE_CYCLES + 1);
  wire [1:0] neg_d;
  wire [1:0] pos_d;
  wire [1:0] hp_d;
  wire [1:0] settled_d;

  for (genvar i = 0; i < 2; i++) begin : g_side
    logic [1:0] pwr;
    logic live;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    assign pwr = cfg.op_ctrl[OSPWR_LPWR_LSB + 2 * i +: 2];
    assign hp_d[i] = cfg.op_ctrl[OSPWR_LMODE_BIT + i];
    // Power field acts the same in line and headphone mode
    assign neg_d[i] = (pwr == OSPWR_PWR_BOTH) || (pwr == OSPWR_PWR_NEG_ONLY);
    assign pos_d[i] = (pwr == OSPWR_PWR_BOTH) || (pwr == OSPWR_PWR_POS_ONLY);
    assign live = hp_d[i] && (pwr != OSPWR_PWR_DOWN);
    assign cnt_nxt = !live ? '0 : (cnt_r == CW'(SETTLE_CYCLES)) ? cnt_r : cnt_r + 1'h1;
    assign settled_d[i] = live && (cnt_r == CW'(SETTLE_CYCLES));
    always_ff @(posedge clk) begin
      if (reset) cnt_r <= '0;
      else cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cfg.neg_en <= '0;
      cfg.pos_en <= '0;
      cfg.hp_mode <= '0;
      cfg.settled <= '0;
    end else begin
      cfg.neg_en <= neg_d;
      cfg.pos_en <= pos_d;
      cfg.hp_mode <= hp_d;
      cfg.settled <= settled_d;
    end
  end

  if (SETTLE_CYCLES < 1) begin : g_chk
    $error("SETTLE_CYCLES must be at least one");
  end
endmodule

/* hdl/ospwr_top.sv */
// Output stage control and decimator power register bank
//
// Notes on behaviour
// - Output stage control at 0x43, 8 bits, reset 0x0F, bits 7:6 reserved.
// - Bit 5 picks right output mode: 0 line output, 1 headphone.
// - Bit 4 picks left output mode: 0 line output, 1 headphone.
// - Bits 3:2 right power: 00 both, 01 negative, 10 positive, 11 off.
// - Bits 1:0 left power: 00 both, 01 negative, 10 positive, 11 off.
// - Decimator power control at 0x44, 8 bits, reset 0x00, all off.
// - Bits 7:4 power rate converter decimators 3 to 0; 1 is on.
// - Bits 3:0 power converter digital filters 3 to 0; 1 is on.
// - Filter enable bits gate the filter clocks, decimator bits the decimator clocks, per channel.
// - Digital microphone channel runs on its filter enable alone.
`timescale 1ns/10ps
module ospwr_top import ospwr_pkg::*; #(
  parameter int SETTLE_CYCLES = OSPWR_SETTLE_CYC,
  parameter int FILT_DIV = OSPWR_FILT_DIV
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [3:0] adc_en,
  input wire logic [3:0] dmic_sel,
  output logic right_headphone_mode_sel,
  output logic left_headphone_mode_sel,
  output logic right_negative_output_en,
  output logic right_positive_output_en,
  output logic left_negative_output_en,
  output logic left_positive_output_en,
  output logic [1:0] hp_settled,
  output logic [3:0] filter_clk_en,
  output logic [3:0] decimator_clk_en,
  output logic [3:0] filter_run,
  output logic [3:0] adc_analog_en
);
  logic [7:0] op_r;
  logic [7:0] dec_r;
  logic [7:0] rdata_r;
  logic [7:0] rd_mux;
  logic [7:0] status;

  ospwr_cfg_if cfg ();

  // Bus decode
  wire sel_op = (addr == OSPWR_OP_STAGE_ADDR);
  wire sel_dec = (addr == OSPWR_DECIM_ADDR);
  wire sel_stat = (addr == OSPWR_STATUS_ADDR);
  wire wr_op = wr && sel_op;
  wire wr_dec = wr && sel_dec;

  // Named views of the decimator power and output stage power fields
  wire decimator3_power = dec_r[OSPWR_DEC_LSB + 3];
  wire decimator2_power = dec_r[OSPWR_DEC_LSB + 2];
  wire decimator1_power = dec_r[OSPWR_DEC_LSB + 1];
  wire decimator0_power = dec_r[OSPWR_DEC_LSB + 0];
  wire [1:0] right_stage_power_field = op_r[OSPWR_RPWR_LSB +: 2];
  wire [1:0] left_stage_power_field = op_r[OSPWR_LPWR_LSB +: 2];

  always_ff @(posedge clk) begin
    if (reset) begin
      op_r <= OSPWR_OP_STAGE_RST;
      dec_r <= OSPWR_DECIM_RST;
    end else begin
      if (wr_op) op_r <= wdata;
      if (wr_dec) dec_r <= wdata;
    end
  end

  assign status = {cfg.run, 2'h0, cfg.settled};
  assign rd_mux = sel_op ? op_r :
                  sel_dec ? dec_r :
                  sel_stat ? status : OSPWR_UNMAPPED_DATA;

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) rdata_r <= 8'h00;
    else rdata_r <= rd ? rd_mux : 8'h00;
  end
  assign rdata = rdata_r;

  assign cfg.op_ctrl = op_r;
  assign cfg.dec_ctrl = dec_r;
  assign cfg.adc_en = adc_en;
  assign cfg.dmic_sel = dmic_sel;

  ospwr_stage #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_stage (
    .clk(clk),
    .reset(reset),
    .cfg(cfg)
  );

  ospwr_gate #(.FILT_DIV(FILT_DIV)) u_gate (
    .clk(clk),
    .reset(reset),
    .cfg(cfg)
  );

  assign left_headphone_mode_sel = cfg.hp_mode[0];
  assign right_headphone_mode_sel = cfg.hp_mode[1];
  assign left_negative_output_en = cfg.neg_en[0];
  assign right_negative_output_en = cfg.neg_en[1];
  assign left_positive_output_en = cfg.pos_en[0];
  assign right_positive_output_en = cfg.pos_en[1];
  assign hp_settled = cfg.settled;
  assign filter_clk_en = cfg.filt_clk;
  assign decimator_clk_en = cfg.dec_clk;
  assign filter_run = cfg.run;
  assign adc_analog_en = cfg.analog;

  // Settle counter watched from outside the stage
  logic [31:0] hp_live_cnt_r;
  wire right_live = cfg.op_ctrl[OSPWR_RMODE_BIT] && (right_stage_power_field != OSPWR_PWR_DOWN);
  always_ff @(posedge clk) begin
    if (reset) hp_live_cnt_r <= 32'h0000_0000;
    else if (!right_live) hp_live_cnt_r <= 32'h0000_0000;
    else if (hp_live_cnt_r != 32'hFFFF_FFFF) hp_live_cnt_r <= hp_live_cnt_r + 32'h0000_0001;
  end

  // Clock enable spacing helper
  logic [31:0] since_tick_r;
  logic seen_tick_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      since_tick_r <= 32'h0000_0000;
      seen_tick_r <= 1'h0;
    end else if (|filter_clk_en) begin
      since_tick_r <= 32'h0000_0000;
      seen_tick_r <= 1'h1;
    end else if (!(|dec_r[3:0])) begin
      seen_tick_r <= 1'h0;
    end else begin
      since_tick_r <= since_tick_r + 32'h0000_0001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  op_reset_value_a: assert property ($past(reset) |-> op_r == OSPWR_OP_STAGE_RST)
    else $error("output stage control not at reset value");

  dec_reset_value_a: assert property ($past(reset) |-> dec_r == OSPWR_DECIM_RST)
    else $error("decimator power control not at reset value");

  right_mode_pin_a: assert property (wr_op |-> ##2
      right_headphone_mode_sel == $past(wdata[OSPWR_RMODE_BIT], 2))
    else $error("right mode output does not follow bit 5");

  left_mode_pin_a: assert property (wr_op |-> ##2
      left_headphone_mode_sel == $past(wdata[OSPWR_LMODE_BIT], 2))
    else $error("left mode output does not follow bit 4");

  right_power_decode_a: assert property (##1 1'h1 |->
      right_negative_output_en == !$past(right_stage_power_field[1]) &&
      right_positive_output_en == !$past(right_stage_power_field[0]))
    else $error("right output stage enables wrong for power field");

  left_power_decode_a: assert property (##1 1'h1 |->
      left_negative_output_en == !$past(left_stage_power_field[1]) &&
      left_positive_output_en == !$past(left_stage_power_field[0]))
    else $error("left output stage enables wrong for power field");

  settle_wait_a: assert property ($rose(hp_settled[1]) |->
      hp_live_cnt_r == 32'(SETTLE_CYCLES + 1))
    else $error("right headphone settle flag at wrong time");

  write_readback_a: assert property ((wr_op ##1 (rd && sel_op && !wr)) |=>
      rdata == $past(wdata, 2))
    else $error("output stage control read back differs from write");

  dec_readback_a: assert property ((rd && sel_dec) |=> rdata == $past(dec_r))
    else $error("decimator power control read back differs");

  dec_clk_gate_a: assert property ((decimator_clk_en & ~$past({decimator3_power,
      decimator2_power, decimator1_power, decimator0_power})) == 4'h0)
    else $error("decimator clock enabled while powered down");

  filt_clk_gate_a: assert property ((filter_clk_en & ~$past(dec_r[3:0])) == 4'h0)
    else $error("filter clock enabled while powered down");

  tick_spacing_a: assert property ((|filter_clk_en && seen_tick_r &&
      $past(|dec_r[3:0])) |-> since_tick_r == 32'(FILT_DIV - 1))
    else $error("filter clock enables not evenly spaced");

  analog_pair_a: assert property (##1 1'h1 |->
      adc_analog_en == ($past(dec_r[3:0]) & $past(adc_en)))
    else $error("analog channel enable not filter and converter enable");

  dmic_runs_a: assert property ((dmic_sel[0] && !adc_en[0] && dec_r[0]) |=>
      filter_run[0])
    else $error("digital microphone channel not processed");

  unmapped_zero_a: assert property ((rd && !sel_op && !sel_dec && !sel_stat) |=>
      rdata == OSPWR_UNMAPPED_DATA)
    else $error("unmapped read not zero");

  cover_op_write_c: cover property (wr_op ##1 (rd && sel_op));
  cover_hp_settle_c: cover property ($rose(hp_settled[1]));
  cover_dmic_run_c: cover property (dmic_sel[1] && !adc_en[1] && dec_r[1] ##1 filter_run[1]);
  cover_all_filters_c: cover property (filter_clk_en == 4'hF);
endmodule

/* test/testbench.sv */
// Self-checking testbench for the output stage and decimator power register bank
`timescale 1ns/10ps
module testbench import ospwr_pkg::*;;
  localparam int SETTLE_N = 8;
  localparam int DIV_N = 4;
  localparam int WIN = 16;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] adc_en = 4'h0;
  logic [3:0] dmic_sel = 4'h0;
  logic [7:0] rdata;
  logic rmode, lmode, rneg, rpos, lneg, lpos;
  logic [1:0] hp_settled;
  logic [3:0] filter_clk_en, decimator_clk_en, filter_run, adc_analog_en;
  logic [7:0] exp_q[$];
  logic rd_pend = 1'b0;
  logic [31:0] lfsr_st = 32'h9770_9336;
  int fail_count = 0;
  int comparisons = 0;
  wire [7:0] pins = {2'b00, rmode, lmode, rneg, rpos, lneg, lpos};

  always #5 clk = ~clk;

  ospwr_top #(.SETTLE_CYCLES(SETTLE_N), .FILT_DIV(DIV_N)) u_dut (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .adc_en(adc_en), .dmic_sel(dmic_sel),
    .right_headphone_mode_sel(rmode), .left_headphone_mode_sel(lmode),
    .right_negative_output_en(rneg), .right_positive_output_en(rpos),
    .left_negative_output_en(lneg), .left_positive_output_en(lpos),
    .hp_settled(hp_settled), .filter_clk_en(filter_clk_en),
    .decimator_clk_en(decimator_clk_en), .filter_run(filter_run),
    .adc_analog_en(adc_analog_en)
  );

  function automatic logic [7:0] rnd();
    lfsr_st = {lfsr_st[30:0], lfsr_st[31] ^ lfsr_st[21] ^ lfsr_st[1] ^ lfsr_st[0]};
    return lfsr_st[7:0];
  endfunction

  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t rdata got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t outputs got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
  endtask

  task automatic idle(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic results;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Read data stands only in the cycle after the strobe, zero otherwise
  always @(posedge clk) begin
    if (rd_pend)
      chk_rd(rdata, exp_q.pop_front());
    else if (!reset)
      chk_rd(rdata, 8'h00);
    rd_pend <= rd;
  end

  initial begin
    #50_000;
    fail_count++;
    results;
  end

  initial begin
    logic [7:0] d, a, m, fr;
    int cnt[8];
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    rd_reg(OSPWR_OP_STAGE_ADDR, 8'h0F);
    rd_reg(OSPWR_DECIM_ADDR, 8'h00);
    idle(1);
    chk_pin(pins, 8'h00);
    for (int i = 0; i < 16; i++) begin
      m = rnd();
      d = {m[7:4], i[3:0]};
      wr_reg(OSPWR_OP_STAGE_ADDR, d);
      rd_reg(OSPWR_OP_STAGE_ADDR, d);
      idle(1);
      chk_pin(pins, {2'b00, d[5:4], ~d[3], ~d[2], ~d[1], ~d[0]});
    end
    // Both sides in headphone mode and powered, then right stage off
    wr_reg(OSPWR_OP_STAGE_ADDR, 8'h30);
    idle(3);
    chk_pin({6'h00, hp_settled}, 8'h00);
    idle(SETTLE_N + 4);
    chk_pin({6'h00, hp_settled}, 8'h03);
    wr_reg(OSPWR_OP_STAGE_ADDR, 8'h3C);
    idle(3);
    chk_pin({6'h00, hp_settled}, 8'h01);
    for (int i = 0; i < 8; i++) begin
      d = rnd();
      a = rnd();
      m = rnd();
      adc_en <= a[3:0];
      dmic_sel <= m[3:0];
      fr = {4'h0, d[3:0] & (a[3:0] | m[3:0])};
      wr_reg(OSPWR_DECIM_ADDR, d);
      rd_reg(OSPWR_DECIM_ADDR, d);
      idle(2);
      chk_pin({filter_run, adc_analog_en}, {fr[3:0], d[3:0] & a[3:0]});
      rd_reg(OSPWR_STATUS_ADDR, {fr[3:0], 4'h1});
      idle(1);
      foreach (cnt[c]) cnt[c] = 0;
      repeat (WIN) begin
        @(posedge clk);
        for (int c = 0; c < 4; c++) begin
          cnt[c] += int'(filter_clk_en[c]);
          cnt[c + 4] += int'(decimator_clk_en[c]);
        end
      end
      for (int c = 0; c < 8; c++)
        chk_pin(8'(cnt[c]), d[c] ? 8'(WIN / DIV_N) : 8'h00);
    end
    wr_reg(8'h50, 8'hA5);
    rd_reg(8'h50, OSPWR_UNMAPPED_DATA);
    rd_reg(OSPWR_OP_STAGE_ADDR, 8'h3C);
    idle(2);
    // Second reset in mid-run restores both registers
    reset <= 1'b1;
    idle(2);
    reset <= 1'b0;
    rd_reg(OSPWR_OP_STAGE_ADDR, 8'h0F);
    rd_reg(OSPWR_DECIM_ADDR, 8'h00);
    idle(3);
    chk_pin({filter_run, adc_analog_en}, 8'h00);
    results;
  end
endmodule
